// File: core/acc_config_regs.sv
// analog front and sync/calibration configuration registers with control outputs
// assumes the serial decoder gives one-cycle write/read strobes with address and data
// Contract
// - writing one to bit 7 resets device
// - bit 6 turns open/short current sources on
// - regulator enable resets to one
// - low power acts only while amplifier enabled
// - bit 3 enables amplifier, reset off
// - gain is two to the gain code
// - master select bit, resets to one
// - mode 4 master: float or drive open-drain
// - coefficient write, taken only with readback select set, reaches math copy on convert
// - readback select picks interface or math copy
// - skip flags drop their coefficient from correction
`default_nettype none
module acc_config_regs
    import acc_pkg::*;
#(
    parameter int COEF_W = ACC_COEF_W,
    parameter int NCOEF = ACC_NCOEF
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_cal_wr,
    input wire logic i_cal_rd,
    input wire logic [$clog2(NCOEF)-1:0] i_cal_idx,
    input wire logic [COEF_W-1:0] i_cal_wdata,
    output logic [COEF_W-1:0] o_cal_rdata,
    output logic o_cal_rvalid,
    input wire logic i_convert_cmd,
    input wire logic [1:0] i_seq_mode,
    input wire logic i_sync_pin_in,
    output logic o_sync_pin_out,
    output logic o_sync_pin_oe,
    output logic o_device_reset,
    output logic o_open_short_detect_enable,
    output logic o_regulator_enable,
    output logic o_amp_low_power,
    output logic o_gain_amp_enable,
    output logic [7:0] o_gain_factor,
    output logic o_sync_master,
    output logic [NCOEF-1:0] o_coef_use,
    output logic [NCOEF-1:0] [COEF_W-1:0] o_math_coef
);
    logic [7:0] analog_front_config;
    logic [7:0] sync_and_calibration_config;
    logic rst_req;
    logic cal_rd_d;
    acc_state_t state;
    acc_state_t next_state;

    acc_coef_if #(.W(COEF_W), .N(NCOEF)) cif ();

    function automatic logic [7:0] gain_of(input logic [2:0] code);
        gain_of = 8'h01 << code;
    endfunction

    // ========================================
    // soft reset sequencing: pulse, then one settle cycle
    assign rst_req = i_reg_wr && i_reg_addr == ACC_ADDR_AFC && i_reg_wdata[ACC_B_RST];

    always_comb begin
        case (state)
            ACC_ST_RUN: next_state = rst_req ? ACC_ST_RESET : ACC_ST_RUN;
            ACC_ST_RESET: next_state = ACC_ST_HOLD;
            ACC_ST_HOLD: next_state = ACC_ST_RUN;
            default: next_state = ACC_ST_RUN;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state <= ACC_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_device_reset <= 1'b0;
        end else begin
            o_device_reset <= next_state == ACC_ST_RESET;
        end
    end

    // ========================================
    // analog front register; reset bit self-clears and reads zero
    always_ff @(posedge i_core_clk) begin
        if (i_reset || state == ACC_ST_RESET) begin
            analog_front_config <= ACC_AFC_RESET;
        end else if (i_reg_wr && i_reg_addr == ACC_ADDR_AFC) begin
            analog_front_config <= {1'b0, i_reg_wdata[ACC_B_OSD:0]};
        end
    end

    // ========================================
    // sync and calibration register; reserved bit kept as written
    always_ff @(posedge i_core_clk) begin
        if (i_reset || state == ACC_ST_RESET) begin
            sync_and_calibration_config <= ACC_SCC_RESET;
        end else if (i_reg_wr && i_reg_addr == ACC_ADDR_SCC) begin
            sync_and_calibration_config <= i_reg_wdata;
        end
    end

    // ========================================
    // register readback
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            case (i_reg_addr)
                ACC_ADDR_AFC: o_reg_rdata <= analog_front_config;
                ACC_ADDR_SCC: o_reg_rdata <= sync_and_calibration_config;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ========================================
    // analog controls
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_open_short_detect_enable <= ACC_AFC_RESET[ACC_B_OSD];
            o_regulator_enable <= ACC_AFC_RESET[ACC_B_REG];
            o_amp_low_power <= 1'b0;
            o_gain_amp_enable <= ACC_AFC_RESET[ACC_B_AMP];
            o_gain_factor <= gain_of(ACC_AFC_RESET[ACC_B_GAIN_HI:0]);
        end else begin
            o_open_short_detect_enable <= analog_front_config[ACC_B_OSD];
            o_regulator_enable <= analog_front_config[ACC_B_REG];
            // gated so a disabled amplifier never sees the power mode
            o_amp_low_power <= analog_front_config[ACC_B_LP] & analog_front_config[ACC_B_AMP];
            o_gain_amp_enable <= analog_front_config[ACC_B_AMP];
            o_gain_factor <= gain_of(analog_front_config[ACC_B_GAIN_HI:0]);
        end
    end

    // ========================================
    // sync pin and coefficient use
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_sync_master <= ACC_SCC_RESET[ACC_B_MASTER];
            o_sync_pin_oe <= 1'b0;
            // follows the reset skip flags so the output agrees with the register from the first cycle
            o_coef_use <= ~ACC_SCC_RESET[ACC_B_SKIP_HI:0];
        end else begin
            o_sync_master <= sync_and_calibration_config[ACC_B_MASTER];
            // open-drain: only ever pulls low, so enable alone carries the level
            o_sync_pin_oe <= i_seq_mode == ACC_SEQ_MODE4 && sync_and_calibration_config[ACC_B_MASTER]
                && !sync_and_calibration_config[ACC_B_FLOAT];
            o_coef_use <= ~sync_and_calibration_config[ACC_B_SKIP_HI:0];
        end
    end
    assign o_sync_pin_out = 1'b0;

    // ========================================
    // calibration coefficient path
    assign cif.wr = i_cal_wr && sync_and_calibration_config[ACC_B_CALSEL];
    assign cif.idx = i_cal_idx;
    assign cif.wdata = i_cal_wdata;
    assign cif.convert = i_convert_cmd;
    assign cif.sel_iface = sync_and_calibration_config[ACC_B_CALSEL];
    assign o_cal_rdata = cif.rdata;
    assign o_math_coef = cif.math;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cal_rd_d <= 1'b0;
        end else begin
            cal_rd_d <= i_cal_rd;
        end
    end
    assign o_cal_rvalid = cal_rd_d;

    acc_coef_store #(.W(COEF_W), .N(NCOEF)) u_store (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .cif(cif.store)
    );

    // ========================================
    // checks
    sequence s_rst_write;
        rst_req && state == ACC_ST_RUN;
    endsequence
    sequence s_rst_pulse;
        o_device_reset ##1 !o_device_reset;
    endsequence

    AST_SOFT_RESET: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_rst_write |=> s_rst_pulse)
        else $error("soft reset pulse wrong");
    AST_SOFT_RESET_DEFAULTS: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_rst_write |-> ##2 analog_front_config == ACC_AFC_RESET)
        else $error("registers not restored by soft reset");
    AST_OSD: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_open_short_detect_enable == $past(analog_front_config[ACC_B_OSD]))
        else $error("open/short enable mismatch");
    AST_REG_RESET: assert property (@(posedge i_core_clk)
        i_reset |=> o_regulator_enable && analog_front_config[ACC_B_REG])
        else $error("regulator not on after reset");
    AST_LP_GATED: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !o_gain_amp_enable |-> !o_amp_low_power)
        else $error("low power active with amplifier off");
    AST_AMP_RESET: assert property (@(posedge i_core_clk)
        i_reset |=> !o_gain_amp_enable && o_gain_factor == 8'h01)
        else $error("amplifier not off after reset");
    AST_GAIN: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_reg_wr && i_reg_addr == ACC_ADDR_AFC && state == ACC_ST_RUN && !i_reg_wdata[ACC_B_RST]
        |-> ##2 o_gain_factor == (8'h01 << $past(i_reg_wdata[ACC_B_GAIN_HI:0], 2)))
        else $error("gain factor wrong");
    AST_MASTER: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_sync_master == $past(sync_and_calibration_config[ACC_B_MASTER]))
        else $error("master select mismatch");
    AST_SYNC_DRIVE: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_sync_pin_oe |-> $past(i_seq_mode) == ACC_SEQ_MODE4 && o_sync_master)
        else $error("sync pin driven outside mode 4 master");
    AST_COEF_USE: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_coef_use == ~$past(sync_and_calibration_config[ACC_B_SKIP_HI:0]))
        else $error("coefficient use mismatch");
    AST_RESERVED: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_reg_wr && i_reg_addr == ACC_ADDR_SCC && state == ACC_ST_RUN
        |=> sync_and_calibration_config[7] == $past(i_reg_wdata[7]))
        else $error("reserved bit not stored");
endmodule
`default_nettype wire

// File: core/acc_pkg.sv
// constants for the analog/sync configuration register pair
// assumes a byte-wide register port from the serial interface decoder
package acc_pkg;
    localparam logic [7:0] ACC_ADDR_AFC = 8'h02;
    localparam logic [7:0] ACC_ADDR_SCC = 8'h03;
    localparam logic [7:0] ACC_AFC_RESET = 8'h20;
    localparam logic [7:0] ACC_SCC_RESET = 8'h7C;
    localparam int ACC_B_RST = 7;
    localparam int ACC_B_OSD = 6;
    localparam int ACC_B_REG = 5;
    localparam int ACC_B_LP = 4;
    localparam int ACC_B_AMP = 3;
    localparam int ACC_B_GAIN_HI = 2;
    localparam int ACC_B_FLOAT = 6;
    localparam int ACC_B_MASTER = 5;
    localparam int ACC_B_CALSEL = 4;
    localparam int ACC_B_SKIP_HI = 3;
    localparam logic [1:0] ACC_SEQ_MODE4 = 2'h3;
    localparam int ACC_COEF_W = 24;
    localparam int ACC_NCOEF = 4;
    typedef enum logic [2:0] {
        ACC_ST_RUN = 3'h1,
        ACC_ST_RESET = 3'h2,
        ACC_ST_HOLD = 3'h4
    } acc_state_t;
endpackage

// File: core/acc_coef_if.sv
// carrier for calibration coefficient write/read between top and coefficient store
// assumes a single clock shared by both ends
`default_nettype none
interface acc_coef_if #(parameter int W = 24, parameter int N = 4) ();
    logic wr;
    logic [$clog2(N)-1:0] idx;
    logic [W-1:0] wdata;
    logic convert;
    logic sel_iface;
    logic [W-1:0] rdata;
    logic [N-1:0] [W-1:0] math;
    modport ctrl (output wr, idx, wdata, convert, sel_iface, input rdata, math);
    modport store (input wr, idx, wdata, convert, sel_iface, output rdata, math);
endinterface
`default_nettype wire

// File: core/acc_coef_store.sv
// two-copy calibration coefficient store: interface copy and math copy
// assumes convert is a one-cycle pulse from the command decoder
`default_nettype none
module acc_coef_store
    import acc_pkg::*;
#(
    parameter int W = ACC_COEF_W,
    parameter int N = ACC_NCOEF
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    acc_coef_if.store cif
);
    logic [W-1:0] iface_copy [N];
    logic [W-1:0] math_copy [N];

    // ========================================
    // interface copy
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            for (int k = 0; k < N; k++) iface_copy[k] <= '0;
        end else if (cif.wr) begin
            iface_copy[cif.idx] <= cif.wdata;
        end
    end

    // ========================================
    // math copy follows only on convert
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            for (int k = 0; k < N; k++) math_copy[k] <= '0;
        end else if (cif.convert) begin
            for (int k = 0; k < N; k++) math_copy[k] <= iface_copy[k];
        end
    end

    always_comb begin
        for (int k = 0; k < N; k++) cif.math[k] = math_copy[k];
    end

    // readback source chosen by the select bit
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cif.rdata <= '0;
        end else begin
            cif.rdata <= cif.sel_iface ? iface_copy[cif.idx] : math_copy[cif.idx];
        end
    end

    AST_MATH_ON_CONVERT: assert property (@(posedge i_core_clk) disable iff (i_reset)
        cif.convert |=> math_copy[0] == $past(iface_copy[0]))
        else $error("math copy missed convert");
    AST_MATH_HOLDS: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !cif.convert |=> $stable(math_copy[0]))
        else $error("math copy moved without convert");
endmodule
`default_nettype wire

// File: bench/acc_host_model.sv
// host side model driving the register and coefficient strobes
// assumes one caller at a time; each access waits for its answer edge
`default_nettype none
module acc_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    input wire logic [23:0] i_cal_rdata,
    input wire logic i_cal_rvalid,
    output var logic o_reg_wr,
    output var logic o_reg_rd,
    output var logic [7:0] o_reg_addr,
    output var logic [7:0] o_reg_wdata,
    output var logic o_cal_wr,
    output var logic o_cal_rd,
    output var logic [1:0] o_cal_idx,
    output var logic [23:0] o_cal_wdata,
    output var logic o_convert
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_reg_wr, o_reg_rd, o_cal_wr, o_cal_rd, o_convert} = 5'h00;
        {o_reg_addr, o_reg_wdata, o_cal_idx, o_cal_wdata} = '0;
    end
    // ==========================================
    // accesses
    // software keeps regulator enable set unless the cap pin is fed externally
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_core_clk);
        o_reg_wr <= wr;
        o_reg_rd <= !wr;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_core_clk);
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b0;
        o_reg_wdata <= ~d;
        #1 q = i_reg_rvalid ? i_reg_rdata : 8'hXX;
    endtask
    // coefficient writes take effect only with readback select set; with it clear the store drops them
    task automatic cal_acc(input logic wr, input logic [1:0] i, input logic [23:0] d, output logic [23:0] q);
        @(posedge i_core_clk);
        o_cal_wr <= wr;
        o_cal_rd <= !wr;
        o_cal_idx <= i;
        o_cal_wdata <= d;
        @(posedge i_core_clk);
        o_cal_wr <= 1'b0;
        o_cal_rd <= 1'b0;
        o_cal_wdata <= ~d;
        #1 q = i_cal_rvalid ? i_cal_rdata : 24'hXXXXXX;
    endtask
    task automatic convert();
        @(posedge i_core_clk);
        o_convert <= 1'b1;
        @(posedge i_core_clk);
        o_convert <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the configuration register pair
// assumes the host model as sole bus driver and a pulled-up sync wire
`default_nettype none
module tb;
    import acc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata; logic [1:0] mode;} acc_row_t;
    logic i_core_clk, i_reset, i_reg_wr, i_reg_rd, o_reg_rvalid, i_cal_wr, i_cal_rd, o_cal_rvalid, i_convert_cmd;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_gain_factor, q;
    logic [1:0] i_cal_idx, i_seq_mode;
    logic [23:0] i_cal_wdata, o_cal_rdata, q24;
    logic o_sync_pin_out, o_sync_pin_oe, o_device_reset, o_open_short_detect_enable, o_regulator_enable;
    logic o_amp_low_power, o_gain_amp_enable, o_sync_master;
    logic [3:0] o_coef_use;
    logic [3:0][23:0] o_math_coef;
    wire logic i_sync_pin_in = o_sync_pin_oe ? o_sync_pin_out : 1'b1;
    int miscompares = 0;
    int cmp_count = 0;
    int pulses = 0;
    logic [7:0] afc, scc;
    acc_row_t rows[15] = '{
        '{8'h02, 8'h08, 8'h08, 2'h0}, '{8'h02, 8'h19, 8'h19, 2'h0}, '{8'h02, 8'h2A, 8'h2A, 2'h0},
        '{8'h02, 8'h3B, 8'h3B, 2'h0}, '{8'h02, 8'h5C, 8'h5C, 2'h0}, '{8'h02, 8'h4D, 8'h4D, 2'h0},
        '{8'h02, 8'h7E, 8'h7E, 2'h0}, '{8'h02, 8'h6F, 8'h6F, 2'h0}, '{8'h02, 8'h17, 8'h17, 2'h0},
        '{8'h02, 8'h00, 8'h00, 2'h0}, '{8'h03, 8'h80, 8'h80, 2'h3}, '{8'h03, 8'h35, 8'h35, 2'h3},
        '{8'h03, 8'h75, 8'h75, 2'h3}, '{8'h03, 8'h35, 8'h35, 2'h0}, '{8'h03, 8'h7C, 8'h7C, 2'h3}};
    acc_config_regs acc_config_regs_i (.i_core_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_rvalid, .i_cal_wr, .i_cal_rd, .i_cal_idx, .i_cal_wdata, .o_cal_rdata, .o_cal_rvalid,
        .i_convert_cmd, .i_seq_mode, .i_sync_pin_in, .o_sync_pin_out, .o_sync_pin_oe, .o_device_reset,
        .o_open_short_detect_enable, .o_regulator_enable, .o_amp_low_power, .o_gain_amp_enable, .o_gain_factor,
        .o_sync_master, .o_coef_use, .o_math_coef);
    acc_host_model host_i (.i_core_clk, .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
        .i_cal_rdata(o_cal_rdata), .i_cal_rvalid(o_cal_rvalid), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
        .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata), .o_cal_wr(i_cal_wr), .o_cal_rd(i_cal_rd),
        .o_cal_idx(i_cal_idx), .o_cal_wdata(i_cal_wdata), .o_convert(i_convert_cmd));
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) if (o_device_reset === 1'b1) pulses++;
    // ==========================================
    // checking
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host_i.reg_acc(1'b0, a, 8'h00, q);
        chk(q, exp, "register read");
    endtask
    task automatic chk_out(input logic [7:0] a, input logic [7:0] s);
        chk(o_open_short_detect_enable, a[6], "detect enable");
        chk(o_regulator_enable, a[5], "regulator");
        chk(o_amp_low_power, a[4] & a[3], "low power");
        chk(o_gain_amp_enable, a[3], "amp enable");
        chk(o_gain_factor, 8'h01 << a[2:0], "gain");
        chk(o_sync_master, s[5], "master");
        chk(o_sync_pin_oe, i_seq_mode == ACC_SEQ_MODE4 && s[5] && !s[6], "sync drive");
        chk(o_sync_pin_out, 1'b0, "sync level");
        chk(o_coef_use, 4'(~s[3:0]), "coef use");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog: whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge i_core_clk);
        miscompares++;
        report_and_stop();
    end
    // ==========================================
    // sequence
    initial begin
        i_reset = 1'b1;
        i_seq_mode = 2'h0;
        repeat (6) @(posedge i_core_clk);
        i_reset <= 1'b0;
        rd(ACC_ADDR_AFC, 8'h20);
        rd(ACC_ADDR_SCC, 8'h7C);
        rd(8'h05, 8'h00);
        chk_out(8'h20, 8'h7C);
        $display("test reset done");
        afc = 8'h20;
        scc = 8'h7C;
        foreach (rows[k]) begin
            i_seq_mode <= rows[k].mode;
            host_i.reg_acc(1'b1, rows[k].addr, rows[k].wdata, q);
            rd(rows[k].addr, rows[k].rdata);
            if (rows[k].addr == ACC_ADDR_AFC) afc = rows[k].wdata;
            else scc = rows[k].wdata;
            chk_out(afc, scc);
        end
        $display("test register rows done");
        host_i.cal_acc(1'b1, 2'd1, 24'hA5C3E1, q24);
        host_i.cal_acc(1'b0, 2'd1, 24'h0, q24);
        chk(q24, 24'hA5C3E1, "interface copy");
        chk(o_math_coef[1], 24'h0, "math before convert");
        host_i.convert();
        chk(o_math_coef[1], 24'hA5C3E1, "math after convert");
        host_i.cal_acc(1'b1, 2'd2, 24'h3C3C3C, q24);
        host_i.reg_acc(1'b1, ACC_ADDR_SCC, 8'h6C, q);
        host_i.cal_acc(1'b0, 2'd2, 24'h0, q24);
        chk(q24, 24'h0, "math copy unconverted");
        host_i.cal_acc(1'b1, 2'd1, 24'h5A5A5A, q24); // invalid write on purpose
        host_i.cal_acc(1'b0, 2'd1, 24'h0, q24);
        chk(q24, 24'hA5C3E1, "math copy");
        host_i.reg_acc(1'b1, ACC_ADDR_SCC, 8'h7C, q);
        host_i.cal_acc(1'b0, 2'd1, 24'h0, q24);
        chk(q24, 24'hA5C3E1, "dropped write");
        $display("test coefficients done");
        host_i.reg_acc(1'b1, ACC_ADDR_SCC, 8'h35, q);
        chk(pulses, 24'd0, "no reset pulse yet");
        host_i.reg_acc(1'b1, ACC_ADDR_AFC, 8'h8B, q);
        repeat (3) @(posedge i_core_clk);
        chk(pulses, 24'd1, "reset pulse");
        rd(ACC_ADDR_AFC, 8'h20);
        rd(ACC_ADDR_SCC, 8'h7C);
        $display("test soft reset done");
        host_i.reg_acc(1'b1, ACC_ADDR_AFC, 8'h6F, q);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_reset <= 1'b0;
        rd(ACC_ADDR_AFC, 8'h20);
        chk_out(8'h20, 8'h7C);
        chk(o_math_coef[1], 24'h0, "math after reset");
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
